// ===== dif_pkg.sv
// Constants, carrier structs and state codes for the DDR input formatter.
// Assumes a single 10 MHz core clock that oversamples the link pins.
package dif_pkg;
  localparam int DW = 16;
  localparam int NFLAG = 6;
  localparam int CTRL_W = 6;
  localparam int OBS_W = 11;
  // Register byte offsets.
  localparam logic [7:0] OFS_PORT_CTRL = 8'h00;
  localparam logic [7:0] OFS_INVERT = 8'h04;
  localparam logic [7:0] OFS_LEVELS = 8'h08;
  localparam logic [7:0] OFS_TOP_CTRL = 8'h0c;
  localparam logic [7:0] OFS_MAN_DELAY = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h18;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'h1c;
  localparam logic [7:0] OFS_OBSERVE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  // Field positions.
  localparam int CTL_PATH_SWAP = 0;
  localparam int CTL_FORMAT = 1;
  localparam int CTL_STROBE_LO = 2;
  localparam int CTL_PARITY = 4;
  localparam int CTL_WORD_SWAP = 5;
  localparam int TOP_TUNING_MODE = 0;
  localparam int TOP_TUNE_START = 1;
  localparam int IRQ_CLEAR_BIT = 0;
  localparam int OBS_SEL0_LO = 0;
  localparam int OBS_SEL1_LO = 2;
  localparam int OBS_BIT_LO = 4;
  localparam int OBS_STATIC0 = 8;
  localparam int OBS_STATIC1 = 9;
  localparam int OBS_POLARITY = 10;
  localparam int FLG_ACQ_A = 0;
  localparam int FLG_ACQ_B = 1;
  localparam int FLG_CAL = 2;
  localparam int FLG_TUNE = 3;
  localparam int FLG_PARITY = 4;
  localparam int FLG_TIMING = 5;
  // Reset values.
  localparam logic [CTRL_W-1:0] RST_PORT_CTRL = 6'h00;
  localparam logic [DW-1:0] RST_INVERT = 16'h0000;
  localparam logic [DW-1:0] RST_LEVEL = 16'h0000;
  localparam logic [3:0] RST_MANUAL = 4'h0;
  localparam logic RST_TUNING_MODE = 1'b0;
  localparam logic [NFLAG-1:0] RST_IRQ_EN = 6'h00;
  localparam logic [OBS_W-1:0] RST_OBSERVE = 11'h000;
  // Strobe use and observation sources.
  localparam logic [1:0] STB_NONE = 2'h0;
  localparam logic [1:0] STB_ENABLE = 2'h1;
  localparam logic [1:0] STB_SYNC = 2'h2;
  localparam logic [1:0] OBS_STATIC = 2'h0;
  localparam logic [1:0] OBS_IRQ = 2'h1;
  localparam logic [1:0] OBS_CLK = 2'h2;
  localparam logic [1:0] OBS_DATA = 2'h3;
  // Timing counts in core cycles, then AXI response codes.
  localparam logic [7:0] HP_MAX = 8'hff;
  localparam logic [7:0] DRIFT_TOL = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {T_IDLE, T_MEAS, T_DONE} tune_t;

  typedef struct packed {
    logic clk_level;
    logic [DW-1:0] data;
    logic strobe;
  } link_t;

  typedef struct packed {
    logic [DW-1:0] i;
    logic [DW-1:0] q;
    logic valid;
    logic start;
  } sample_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;
endpackage

// ===== lvds_ddr_input_formatter.sv
// DDR input formatter: link capture, formatting, flags and observation.
// Assumes link pins are asynchronous to clk and event inputs are not.
//
// Functional notes
// - Split DDR bus into paths A and B.
// - Path swap bit exchanges A and B.
// - Interleaved: I is A, Q is B.
// - Folded: I upper bytes, Q lower bytes.
// - Strobe low in enable mode inserts constants.
// - Strobe as parity bit flags mismatches.
// - Strobe marks stream start in sync mode.
// - Interrupt routable to either pin, selectable polarity.
// - Only enabled flags assert the interrupt.
// - Four ready flags on process completion.
// - Error flags for parity and delay drift.
// - Clear bit resets flags and interrupt.
// - Observation pins select interrupt, signal or static.
// - Sampling point from 16-step compensation delay.
// - Tuning mode bit picks auto or manual.
// - Manual mode uses four-bit delay field.
// - Per-line polarity inversion before demultiplexing.
// - Word swap reverses the sixteen lines.
`timescale 1ns/10ps
`default_nettype none
module lvds_ddr_input_formatter
  import dif_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire link_t link,
  input wire logic mixer_acq_done_a,
  input wire logic mixer_acq_done_b,
  input wire logic auto_cal_done,
  input wire axi_req_t axi_req,
  output var axi_rsp_t axi_rsp,
  output var sample_t sample,
  output var logic irq_output,
  output var logic observe_pin_zero,
  output var logic observe_pin_one
);
  typedef struct packed {
    link_t lnk1;
    link_t lnk2;
    logic clk_prev;
    logic arm_a;
    logic arm_b;
    logic [3:0] cnt_a;
    logic [3:0] cnt_b;
    logic [DW-1:0] word_a;
    logic stb_a;
    logic [7:0] hp_cnt;
    logic [7:0] cal_half;
    logic [3:0] auto_del;
    logic seen;
    tune_t tstate;
    logic [CTRL_W-1:0] ctrl;
    logic [DW-1:0] inv;
    logic [DW-1:0] lvl_i;
    logic [DW-1:0] lvl_q;
    logic [3:0] manual;
    logic tmode;
    logic [NFLAG-1:0] ien;
    logic [NFLAG-1:0] flags;
    logic [OBS_W-1:0] obs;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    axi_rsp_t rsp;
    sample_t smp;
    logic irq;
    logic pin0;
    logic pin1;
  } state_t;

  state_t s;
  state_t next_s;
  logic [DW-1:0] inv;
  logic [DW-1:0] fixed;
  logic [DW-1:0] pa;
  logic [DW-1:0] pb;
  logic [NFLAG-1:0] ev;
  logic [31:0] wr_val;
  logic [7:0] half;
  logic [7:0] drift;
  logic [3:0] delay;
  logic [1:0] stb_mode;
  logic rise;
  logic fall;
  logic edge_seen;
  logic cap_a;
  logic cap_b;
  logic wr_fire;
  logic clr;
  logic tune_go;
  logic dc;

  function automatic logic [31:0] regread(input logic [7:0] a,
                                          input state_t st);
    regread = 32'h0000_0000;
    case (a)
      OFS_PORT_CTRL: regread[CTRL_W-1:0] = st.ctrl;
      OFS_INVERT: regread[DW-1:0] = st.inv;
      OFS_LEVELS: regread = {st.lvl_q, st.lvl_i};
      OFS_TOP_CTRL: regread[TOP_TUNING_MODE] = st.tmode;
      OFS_MAN_DELAY: regread[3:0] = st.manual;
      OFS_IRQ_EN: regread[NFLAG-1:0] = st.ien;
      OFS_IRQ_FLAGS: regread[NFLAG-1:0] = st.flags;
      OFS_OBSERVE: regread[OBS_W-1:0] = st.obs;
      OFS_STATUS: regread[15:0] = {st.cal_half, st.auto_del, 2'h0, st.tstate};
      default: regread = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      OFS_PORT_CTRL, OFS_INVERT, OFS_LEVELS, OFS_TOP_CTRL, OFS_MAN_DELAY,
      OFS_IRQ_EN, OFS_IRQ_FLAGS, OFS_IRQ_CTRL, OFS_OBSERVE,
      OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] be);
    merge = old;
    for (int b = 0; b < 4; b++)
    begin
      if (be[b])
      begin
        merge[8*b +: 8] = d[8*b +: 8];
      end
    end
  endfunction

  assign inv = s.lnk2.data ^ s.inv;
  for (genvar g = 0; g < DW; g++)
  begin : g_map
    assign fixed[g] = s.ctrl[CTL_WORD_SWAP] ? inv[DW-1-g] : inv[g];
  end

  // Edges are found on the synchronised copy, never on the first stage.
  assign rise = s.lnk2.clk_level & ~s.clk_prev;
  assign fall = ~s.lnk2.clk_level & s.clk_prev;
  assign edge_seen = rise | fall;
  assign cap_a = s.arm_a & (s.cnt_a == 4'h0);
  assign cap_b = s.arm_b & (s.cnt_b == 4'h0);
  assign delay = s.tmode ? s.manual : s.auto_del;
  assign half = (s.hp_cnt == HP_MAX) ? HP_MAX : s.hp_cnt + 8'h01;
  assign drift = (half > s.cal_half) ? half - s.cal_half : s.cal_half - half;
  assign pa = s.ctrl[CTL_PATH_SWAP] ? fixed : s.word_a;
  assign pb = s.ctrl[CTL_PATH_SWAP] ? s.word_a : fixed;
  assign stb_mode = s.ctrl[CTL_STROBE_LO +: 2];
  assign dc = (stb_mode == STB_ENABLE) & ~s.stb_a;
  assign wr_fire = s.aw_got & s.w_got & ~s.rsp.bvalid;
  assign wr_val = merge(regread(s.awaddr, s), s.wdata, s.wstrb);
  assign clr = wr_fire & (s.awaddr == OFS_IRQ_CTRL) & wr_val[IRQ_CLEAR_BIT];
  assign tune_go = wr_fire & (s.awaddr == OFS_TOP_CTRL)
                   & wr_val[TOP_TUNE_START];

  always_comb
  begin
    next_s = s;
    ev = '0;
    next_s.lnk1 = link;
    next_s.lnk2 = s.lnk1;
    next_s.clk_prev = s.lnk2.clk_level;
    if (cap_a)
    begin
      next_s.arm_a = 1'b0;
      next_s.word_a = fixed;
      next_s.stb_a = s.lnk2.strobe;
    end
    else if (s.arm_a)
    begin
      next_s.cnt_a = s.cnt_a - 4'h1;
    end
    if (rise)
    begin
      next_s.arm_a = 1'b1;
      next_s.cnt_a = delay;
    end
    if (cap_b)
    begin
      next_s.arm_b = 1'b0;
    end
    else if (s.arm_b)
    begin
      next_s.cnt_b = s.cnt_b - 4'h1;
    end
    if (fall)
    begin
      next_s.arm_b = 1'b1;
      next_s.cnt_b = delay;
    end
    next_s.smp.valid = cap_b;
    next_s.smp.start = 1'b0;
    if (cap_b)
    begin
      if (dc)
      begin
        next_s.smp.i = s.lvl_i;
        next_s.smp.q = s.lvl_q;
      end
      else if (s.ctrl[CTL_FORMAT])
      begin
        next_s.smp.i = pa;
        next_s.smp.q = pb;
      end
      else
      begin
        next_s.smp.i = {pa[15:8], pb[15:8]};
        next_s.smp.q = {pa[7:0], pb[7:0]};
      end
      next_s.smp.start = (stb_mode == STB_SYNC) & s.stb_a;
    end
    ev[FLG_PARITY] = s.ctrl[CTL_PARITY] & (cap_a | cap_b)
                     & (^{fixed, s.lnk2.strobe});
    ev[FLG_ACQ_A] = mixer_acq_done_a;
    ev[FLG_ACQ_B] = mixer_acq_done_b;
    ev[FLG_CAL] = auto_cal_done;
    // Half-period timer saturates so a stopped link cannot wrap it.
    next_s.hp_cnt = edge_seen ? 8'h00 : half;
    case (s.tstate)
      T_IDLE:
      begin
        next_s.seen = 1'b0;
      end
      T_MEAS:
      begin
        if (edge_seen)
        begin
          next_s.seen = 1'b1;
          if (s.seen)
          begin
            next_s.cal_half = half;
            next_s.auto_del = (half[7:5] != 3'h0) ? 4'hf : half[4:1];
            next_s.tstate = T_DONE;
            ev[FLG_TUNE] = 1'b1;
          end
        end
      end
      T_DONE:
      begin
        if (edge_seen && !s.tmode && drift > DRIFT_TOL)
        begin
          ev[FLG_TIMING] = 1'b1;
        end
      end
      default:
      begin
        next_s.tstate = T_IDLE;
      end
    endcase
    if (tune_go)
    begin
      next_s.tstate = T_MEAS;
      next_s.seen = 1'b0;
    end
    // Register writes.
    if (s.rsp.bvalid && axi_req.bready)
    begin
      next_s.rsp.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp = mapped(s.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (s.awaddr)
        OFS_PORT_CTRL: next_s.ctrl = wr_val[CTRL_W-1:0];
        OFS_INVERT: next_s.inv = wr_val[DW-1:0];
        OFS_LEVELS:
        begin
          next_s.lvl_i = wr_val[15:0];
          next_s.lvl_q = wr_val[31:16];
        end
        OFS_TOP_CTRL: next_s.tmode = wr_val[TOP_TUNING_MODE];
        OFS_MAN_DELAY: next_s.manual = wr_val[3:0];
        OFS_IRQ_EN: next_s.ien = wr_val[NFLAG-1:0];
        OFS_OBSERVE: next_s.obs = wr_val[OBS_W-1:0];
        default: next_s.ctrl = s.ctrl;
      endcase
    end
    if (s.rsp.awready && axi_req.awvalid)
    begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = axi_req.awaddr;
    end
    if (s.rsp.wready && axi_req.wvalid)
    begin
      next_s.w_got = 1'b1;
      next_s.wdata = axi_req.wdata;
      next_s.wstrb = axi_req.wstrb;
    end
    next_s.rsp.awready = ~next_s.aw_got & ~next_s.rsp.bvalid;
    next_s.rsp.wready = ~next_s.w_got & ~next_s.rsp.bvalid;
    // Register reads answer on the same edge that takes the address.
    if (s.rsp.rvalid && axi_req.rready)
    begin
      next_s.rsp.rvalid = 1'b0;
    end
    if (s.rsp.arready && axi_req.arvalid)
    begin
      next_s.rsp.rvalid = 1'b1;
      next_s.rsp.rdata = regread(axi_req.araddr, s);
      next_s.rsp.rresp = mapped(axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    next_s.rsp.arready = ~next_s.rsp.rvalid;
    next_s.flags = (clr ? '0 : s.flags) | ev;
    next_s.irq = |(next_s.flags & next_s.ien);
    case (s.obs[OBS_SEL0_LO +: 2])
      OBS_IRQ: next_s.pin0 = s.irq;
      OBS_CLK: next_s.pin0 = s.lnk2.clk_level;
      OBS_DATA: next_s.pin0 = fixed[s.obs[OBS_BIT_LO +: 4]];
      default: next_s.pin0 = s.obs[OBS_STATIC0];
    endcase
    case (s.obs[OBS_SEL1_LO +: 2])
      OBS_IRQ: next_s.pin1 = s.irq;
      OBS_CLK: next_s.pin1 = s.lnk2.clk_level;
      OBS_DATA: next_s.pin1 = fixed[s.obs[OBS_BIT_LO +: 4]];
      default: next_s.pin1 = s.obs[OBS_STATIC1];
    endcase
    next_s.pin0 = next_s.pin0 ^ s.obs[OBS_POLARITY];
    next_s.pin1 = next_s.pin1 ^ s.obs[OBS_POLARITY];
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s <= '0;
      s.ctrl <= RST_PORT_CTRL;
      s.inv <= RST_INVERT;
      s.lvl_i <= RST_LEVEL;
      s.lvl_q <= RST_LEVEL;
      s.manual <= RST_MANUAL;
      s.tmode <= RST_TUNING_MODE;
      s.ien <= RST_IRQ_EN;
      s.obs <= RST_OBSERVE;
      s.tstate <= T_IDLE;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign axi_rsp = s.rsp;
  assign sample = s.smp;
  assign irq_output = s.irq;
  assign observe_pin_zero = s.pin0;
  assign observe_pin_one = s.pin1;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_clear_quiet;
    clr && ev == '0;
  endsequence
  sequence s_flags_empty;
    s.flags == '0 && !irq_output;
  endsequence
  sequence s_tune_last_edge;
    s.tstate == T_MEAS && edge_seen && s.seen;
  endsequence

  a_arm_delay: assert property (rise |=> s.arm_a && s.cnt_a == $past(delay))
    else $error("Path A sampling point not loaded from delay.");
  a_manual_pick: assert property (s.tmode |-> delay == s.manual)
    else $error("Manual mode does not use the manual delay.");
  a_interleave_map: assert property (
    cap_b && !dc && s.ctrl[CTL_FORMAT] && !s.ctrl[CTL_PATH_SWAP]
    |=> sample.valid && sample.i == $past(s.word_a)
        && sample.q == $past(fixed))
    else $error("Interleaved mapping wrong.");
  a_folded_map: assert property (
    cap_b && !dc && !s.ctrl[CTL_FORMAT] && s.ctrl[CTL_PATH_SWAP]
    |=> sample.i == {$past(fixed[15:8]), $past(s.word_a[15:8])})
    else $error("Folded mapping with swap wrong.");
  a_dc_level: assert property (
    cap_b && dc |=> sample.i == $past(s.lvl_i)
                    && sample.q == $past(s.lvl_q))
    else $error("Constant level not inserted.");
  a_parity_flag: assert property (
    s.ctrl[CTL_PARITY] && cap_a && (^{fixed, s.lnk2.strobe})
    |=> s.flags[FLG_PARITY])
    else $error("Parity mismatch not flagged.");
  a_flag_clear: assert property (s_clear_quiet |=> s_flags_empty)
    else $error("Clear did not drop flags and interrupt.");
  a_flag_sticky: assert property (
    !clr |=> (s.flags & $past(s.flags)) == $past(s.flags))
    else $error("A flag fell without a clear.");
  a_irq_masked: assert property (
    (s.flags & s.ien) == '0 |-> !irq_output)
    else $error("Interrupt raised by a disabled flag.");
  a_tune_ready: assert property (
    s_tune_last_edge |=> s.flags[FLG_TUNE] ##1 s.tstate == T_DONE)
    else $error("Delay tuning did not report ready.");
  a_pin_route: assert property (
    s.obs[OBS_SEL0_LO +: 2] == OBS_IRQ
    |=> observe_pin_zero == ($past(s.irq) ^ $past(s.obs[OBS_POLARITY])))
    else $error("Interrupt not routed to observation pin zero.");
  a_sync_start: assert property (
    cap_b && stb_mode == STB_SYNC && s.stb_a |=> sample.start)
    else $error("Stream start not marked.");
endmodule
`default_nettype wire

// ===== link_source_model.sv
// Behavioural model of the logic source that drives the DDR sample link.
// Assumes the caller starts one frame at a time and waits for it to end.
`timescale 1ns/10ps
`default_nettype none
module link_source_model
  import dif_pkg::*;
(
  output var link_t link
);
  initial
  begin
    link = '0;
  end

  // coincident clock and data
  // The forwarded clock rises with word A and falls with word B, 800 ns
  // period. It stands still between frames, so tuning sees idle gaps.
  task automatic send(input logic [15:0] a, input logic [15:0] b,
                      input logic sa, input logic sb);
    #37;
    link = '{clk_level: 1'b1, data: a, strobe: sa};
    #400;
    link = '{clk_level: 1'b0, data: b, strobe: sb};
    #400;
    // Held words expire; show the inverse so stale values never match.
    link.data = ~b;
    link.strobe = ~sb;
  endtask
endmodule
`default_nettype wire

// ===== lvds_ddr_input_formatter_test.sv
// Self-checking bench for the DDR input formatter over AXI4-Lite.
// Assumes the link source model and the formatter's package.
`timescale 1ns/10ps
`default_nettype none
module lvds_ddr_input_formatter_test
  import dif_pkg::*;
;
  localparam logic [15:0] inv_mask = 16'h0f0f;
  logic clk;
  logic rstn;
  link_t link;
  logic acq_a;
  logic acq_b;
  logic cal_done;
  axi_req_t req;
  axi_rsp_t rsp;
  sample_t smp;
  logic irq;
  logic obs0;
  logic obs1;
  logic [31:0] got;
  logic [1:0] resp;
  int num_errors;
  int total_checks;

  link_source_model i_src (.link(link));

  lvds_ddr_input_formatter i_dut (
    .clk(clk),
    .rstn(rstn),
    .link(link),
    .mixer_acq_done_a(acq_a),
    .mixer_acq_done_b(acq_b),
    .auto_cal_done(cal_done),
    .axi_req(req),
    .axi_rsp(rsp),
    .sample(smp),
    .irq_output(irq),
    .observe_pin_zero(obs0),
    .observe_pin_one(obs1)
  );

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict;
    if (num_errors == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic timed_out;
    num_errors++;
    $display("[FAIL] %0t ns: wait ran out", $time);
    give_verdict();
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid)
      begin
        resp = rsp.bresp;
        req.bready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    for (int n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid)
      begin
        got = rsp.rdata;
        resp = rsp.rresp;
        req.rready <= 1'b0;
        return;
      end
    end
    timed_out();
  endtask

  // Sends one A/B pair and returns in the cycle that shows the sample.
  task automatic frame(input logic [15:0] a, input logic [15:0] b,
                       input logic sa, input logic sb);
    fork
      i_src.send(a, b, sa, sb);
    join_none
    for (int n = 0; n < 40; n++)
    begin
      @(posedge clk);
      #1;
      if (smp.valid === 1'b1)
        return;
    end
    timed_out();
  endtask

  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    {acq_a, acq_b, cal_done} <= m;
    @(posedge clk);
    {acq_a, acq_b, cal_done} <= 3'b000;
  endtask

  // Expected I and Q: inversion, then line reversal, path swap, format.
  function automatic logic [31:0] model(input logic [15:0] a,
                                        input logic [15:0] b,
                                        input logic [2:0] c);
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] t;
    x = a ^ (c[2] ? inv_mask : 16'h0000);
    y = b ^ (c[2] ? inv_mask : 16'h0000);
    if (c[2])
    begin
      x = {<<{x}};
      y = {<<{y}};
    end
    if (c[0])
    begin
      t = x;
      x = y;
      y = t;
    end
    if (c[1])
      return {x, y};
    return {x[15:8], y[15:8], x[7:0], y[7:0]};
  endfunction

  initial
  begin
    rstn = 1'b0;
    req = '0;
    acq_a = 1'b0;
    acq_b = 1'b0;
    cal_done = 1'b0;
    num_errors = 0;
    total_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd_reg(OFS_PORT_CTRL);
    chk(got, 32'h0);
    rd_reg(8'h3c);
    chk({30'h0, resp}, {30'h0, RESP_SLVERR});
    chk(got, 32'h0);
    wr_reg(OFS_TOP_CTRL, 32'h1);
    wr_reg(OFS_MAN_DELAY, 32'h1);
    rd_reg(OFS_MAN_DELAY);
    chk(got, 32'h1);
    // Every mix of path swap, format and line reversal with inversion.
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(OFS_INVERT, c[2] ? {16'h0, inv_mask} : 32'h0);
      wr_reg(OFS_PORT_CTRL, {26'h0, c[2], 3'b000, c[1:0]});
      frame(16'h1234, 16'habcd, 1'b0, 1'b0);
      chk({smp.i, smp.q}, model(16'h1234, 16'habcd, c[2:0]));
    end
    wr_reg(OFS_INVERT, 32'h0);
    wr_reg(OFS_LEVELS, 32'h5a5a0123);
    wr_reg(OFS_PORT_CTRL, 32'h06);
    frame(16'h1234, 16'habcd, 1'b0, 1'b0);
    chk({smp.i, smp.q}, 32'h01235a5a);
    frame(16'h1234, 16'habcd, 1'b1, 1'b0);
    chk({smp.i, smp.q}, 32'h1234abcd);
    wr_reg(OFS_PORT_CTRL, 32'h0a);
    frame(16'h1111, 16'h2222, 1'b1, 1'b0);
    chk({31'h0, smp.start}, 32'h1);
    frame(16'h1111, 16'h2222, 1'b0, 1'b0);
    chk({31'h0, smp.start}, 32'h0);
    wr_reg(OFS_OBSERVE, 32'h104);
    wr_reg(OFS_IRQ_EN, 32'h10);
    wr_reg(OFS_PORT_CTRL, 32'h12);
    frame(16'h0001, 16'h0003, 1'b1, 1'b0);
    rd_reg(OFS_IRQ_FLAGS);
    chk(got, 32'h0);
    chk({31'h0, obs1}, 32'h0);
    frame(16'h0001, 16'h0003, 1'b1, 1'b1);
    frame(16'h0001, 16'h0003, 1'b1, 1'b0);
    rd_reg(OFS_IRQ_FLAGS);
    chk(got, 32'h10);
    chk({31'h0, irq}, 32'h1);
    chk({30'h0, obs0, obs1}, 32'h3);
    wr_reg(OFS_OBSERVE, 32'h405);
    rd_reg(OFS_OBSERVE);
    chk({30'h0, obs0, obs1}, 32'h0);
    pulse(3'b100);
    rd_reg(OFS_IRQ_FLAGS);
    chk(got, 32'h11);
    wr_reg(OFS_IRQ_CTRL, 32'h1);
    rd_reg(OFS_IRQ_FLAGS);
    chk(got, 32'h0);
    chk({31'h0, irq}, 32'h0);
    chk({30'h0, obs0, obs1}, 32'h3);
    pulse(3'b011);
    rd_reg(OFS_IRQ_FLAGS);
    chk(got, 32'h06);
    chk({31'h0, irq}, 32'h0);
    // Auto tuning: half period of 400 ns is four core cycles.
    wr_reg(OFS_PORT_CTRL, 32'h02);
    wr_reg(OFS_TOP_CTRL, 32'h2);
    frame(16'h0f0f, 16'hf0f0, 1'b0, 1'b0);
    rd_reg(OFS_STATUS);
    chk({got[15:4], 2'b00, got[1:0]}, 32'h0422);
    rd_reg(OFS_IRQ_FLAGS);
    chk({31'h0, got[FLG_TUNE]}, 32'h1);
    frame(16'h4321, 16'h8765, 1'b0, 1'b0);
    chk({smp.i, smp.q}, 32'h43218765);
    // The long idle gap before this frame breaks the measured half period.
    rd_reg(OFS_IRQ_FLAGS);
    chk({31'h0, got[FLG_TIMING]}, 32'h1);
    give_verdict();
  end

  initial
  begin
    #5000000;
    timed_out();
  end
endmodule
`default_nettype wire
